/* rtl/hlt_oneshot_defines.svh */
// Constants for the one-shot / monostable hardware limit timer.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef HLT_ONESHOT_DEFINES_SVH
`define HLT_ONESHOT_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define COUNT_W 8
`define MODE_W 5
`define SYNC_W 3

// ----------------------------------------------------------------
// Mode field encodings
// ----------------------------------------------------------------
`define MODE_HLT_RISE 5'h0c
`define MODE_HLT_FALL 5'h0d
`define MODE_LVL_LOW 5'h0e
`define MODE_LVL_HIGH 5'h0f
`define MODE_MONO_RISE 5'h11
`define MODE_MONO_FALL 5'h12
`define MODE_MONO_BOTH 5'h13

// ----------------------------------------------------------------
// Reset values and synchroniser bit positions
// ----------------------------------------------------------------
`define COUNT_RST 8'h00
`define SYNC_TRIG_BIT 0
`define SYNC_SET_BIT 1
`define SYNC_CLR_BIT 2

`endif

/* rtl/hlt_oneshot_pkg.sv */
// Types for the one-shot / monostable hardware limit timer.
// Assumes the defines header is compiled alongside.
`default_nettype none

package hlt_oneshot_pkg;

   // -------------------------------------------------------------
   // Counter sequencer
   // -------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_PAUSE = 2'b10,
      ST_DONE = 2'b11
   } timer_state_t;

endpackage

`default_nettype wire

/* rtl/sync_two_flop.sv */
// Two-flop level synchroniser, one bit per lane.
// Assumes inputs may change at any time relative to i_clk.
// Assumes the clock runs during reset; i_rst is not used by the lanes.
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop
#(
   parameter int WIDTH = 3
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Data
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_lane
         // No reset: lanes follow the pins through reset, so a toggle
         // or trigger already high at release gives no false edge
         always_ff @(posedge i_clk)
         begin
            meta_r[g] <= i_async[g];
            sync_r[g] <= meta_r[g];
         end
      end
   endgenerate

   assign o_sync = sync_r;

endmodule

`default_nettype wire

/* rtl/edge_detect.sv */
// Rise and fall detector on already synchronised levels.
// Assumes i_level comes from the second flop of a synchroniser.
`timescale 1ns/1ps
`default_nettype none

module edge_detect
#(
   parameter int WIDTH = 3
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Levels and edges
   input wire logic [WIDTH-1:0] i_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);

   logic [WIDTH-1:0] prev_r;

   // History tracks the level through reset, as the synchroniser does
   always_ff @(posedge i_clk)
   begin
      prev_r <= i_level;
   end

   assign o_rise = i_level & ~prev_r;
   assign o_fall = ~i_level & prev_r;

   property p_rise_cause;
      @(posedge i_clk) disable iff (i_rst)
      (|o_rise) |-> ((i_level & ~$past(i_level)) != '0);
   endproperty
   a_rise_cause: assert property (p_rise_cause)
      else $error("rise without a low to high change");

endmodule

`default_nettype wire

/* rtl/hlt_oneshot_timer.sv */
// One-shot and monostable hardware limit timer, 8-bit count.
// Assumes one timer clock; ON set/clear arrive as toggles from the CPU.
//
// How it works
// - Hardware limit: first edge starts, later edges reset
// - After reset edge, counting resumes two clocks later
// - Mode 01100 rising, 01101 falling start/reset
// - Period match resets count and clears ON
// - Trigger edges ignored while ON is clear
// - PWM set pulse on start and reset edges
// - Drive off at pulse match until halt or edge
// - Reset level holds count; active transition starts
// - Mode 01110 low level, 01111 high level
// - Level mode: match clears ON; fresh edge restarts
// - Level mode drive: on at start, off at pulse
// - Monostable starts on edge, stops at period
// - Monostable 10001 rise, 10010 fall, 10011 both
// - Monostable drive only on start, edges ignored
// - Asynchronous ON writes captured safely
`timescale 1ns/1ps
`default_nettype none

`include "hlt_oneshot_defines.svh"

module hlt_oneshot_timer
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Configuration
   input wire logic [`MODE_W-1:0] i_mode,
   input wire logic [`COUNT_W-1:0] i_period_value,
   input wire logic [`COUNT_W-1:0] i_pulse_width_value,
   // Software ON control, each a toggle per write
   input wire logic i_on_set_toggle,
   input wire logic i_on_clr_toggle,
   // External trigger
   input wire logic i_external_trigger_input,
   // Status
   output logic o_on,
   output logic o_running,
   output logic [`COUNT_W-1:0] o_timer_count,
   // To companion PWM
   output logic o_postscaled_match_output,
   output logic o_pwm_period_set,
   output logic o_pwm_drive
);
   import hlt_oneshot_pkg::*;

   // -------------------------------------------------------------
   // Crossing and edge detection
   // -------------------------------------------------------------
   logic [`SYNC_W-1:0] raw_in;
   logic [`SYNC_W-1:0] sync_lvl;
   logic [`SYNC_W-1:0] rise;
   logic [`SYNC_W-1:0] fall;

   // ON writes cross as toggles so a short CPU write is never missed
   assign raw_in = {i_on_clr_toggle, i_on_set_toggle,
                    i_external_trigger_input};

   sync_two_flop #(.WIDTH(`SYNC_W)) u_sync
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(raw_in),
      .o_sync(sync_lvl)
   );

   edge_detect #(.WIDTH(`SYNC_W)) u_edge
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(sync_lvl),
      .o_rise(rise),
      .o_fall(fall)
   );

   logic trig_s;
   logic trig_rise;
   logic trig_fall;
   logic sw_set;
   logic sw_clr;
   assign trig_s = sync_lvl[`SYNC_TRIG_BIT];
   assign trig_rise = rise[`SYNC_TRIG_BIT];
   assign trig_fall = fall[`SYNC_TRIG_BIT];
   assign sw_set = rise[`SYNC_SET_BIT] | fall[`SYNC_SET_BIT];
   assign sw_clr = rise[`SYNC_CLR_BIT] | fall[`SYNC_CLR_BIT];

   // -------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------
   logic is_hlt;
   logic is_lvl;
   logic is_mono;
   logic use_rise;
   logic use_fall;
   logic start_edge;
   logic at_reset_lvl;

   assign is_hlt = (i_mode == `MODE_HLT_RISE) ||
                   (i_mode == `MODE_HLT_FALL);
   assign is_lvl = (i_mode == `MODE_LVL_LOW) ||
                   (i_mode == `MODE_LVL_HIGH);
   assign is_mono = (i_mode == `MODE_MONO_RISE) ||
                    (i_mode == `MODE_MONO_FALL) ||
                    (i_mode == `MODE_MONO_BOTH);
   // Level modes start on the way out of the reset level
   assign use_rise = (i_mode == `MODE_HLT_RISE) ||
                     (i_mode == `MODE_LVL_LOW) ||
                     (i_mode == `MODE_MONO_RISE) ||
                     (i_mode == `MODE_MONO_BOTH);
   assign use_fall = (i_mode == `MODE_HLT_FALL) ||
                     (i_mode == `MODE_LVL_HIGH) ||
                     (i_mode == `MODE_MONO_FALL) ||
                     (i_mode == `MODE_MONO_BOTH);
   assign start_edge = (use_rise & trig_rise) | (use_fall & trig_fall);
   assign at_reset_lvl = is_lvl &
      (trig_s == (i_mode == `MODE_LVL_HIGH));

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   timer_state_t state_r;
   timer_state_t state_nxt;
   logic [`COUNT_W-1:0] count_r;
   logic [`COUNT_W-1:0] count_nxt;
   logic on_r;
   logic on_nxt;
   logic drive_r;
   logic drive_nxt;
   logic pset_r;
   logic pset_nxt;
   logic match_r;
   logic match_nxt;
   logic on_sw;
   logic period_hit;
   logic pulse_hit;
   logic [`COUNT_W-1:0] count_inc;

   // A software set wins over any clear in the same cycle
   assign on_sw = sw_set | (on_r & ~sw_clr);
   assign period_hit = (count_r == i_period_value);
   assign pulse_hit = (count_r == i_pulse_width_value);
   assign count_inc = count_r + 8'h01;

   always_comb
   begin
      state_nxt = state_r;
      count_nxt = count_r;
      on_nxt = on_sw;
      drive_nxt = drive_r;
      pset_nxt = 1'b0;
      match_nxt = 1'b0;
      if (!on_r)
      begin
         // Stopped: no edge can start or reset the count
         state_nxt = ST_IDLE;
         drive_nxt = 1'b0;
      end
      else if (at_reset_lvl)
      begin
         state_nxt = ST_IDLE;
         count_nxt = `COUNT_RST;
         drive_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE, ST_DONE:
            begin
               if (start_edge)
               begin
                  state_nxt = ST_RUN;
                  count_nxt = `COUNT_RST;
                  pset_nxt = 1'b1;
                  drive_nxt = 1'b1;
               end
            end
            ST_RUN, ST_PAUSE:
            begin
               if (is_hlt && start_edge)
               begin
                  // Count sits at zero for two clocks, then resumes
                  state_nxt = ST_PAUSE;
                  count_nxt = `COUNT_RST;
                  pset_nxt = 1'b1;
                  drive_nxt = 1'b1;
               end
               else if (state_r == ST_PAUSE)
                  state_nxt = ST_RUN;
               else if (period_hit)
               begin
                  match_nxt = 1'b1;
                  drive_nxt = 1'b0;
                  if (is_mono)
                     state_nxt = ST_DONE;
                  else
                  begin
                     state_nxt = ST_IDLE;
                     count_nxt = `COUNT_RST;
                     on_nxt = sw_set;
                  end
               end
               else
               begin
                  count_nxt = count_inc;
                  if (pulse_hit)
                     drive_nxt = 1'b0;
               end
            end
            default:
               state_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= ST_IDLE;
         count_r <= `COUNT_RST;
         on_r <= 1'b0;
         drive_r <= 1'b0;
         pset_r <= 1'b0;
         match_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         on_r <= on_nxt;
         drive_r <= drive_nxt;
         pset_r <= pset_nxt;
         match_r <= match_nxt;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   logic running_r;
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         running_r <= 1'b0;
      else
         running_r <= (state_nxt == ST_RUN);
   end

   assign o_on = on_r;
   assign o_running = running_r;
   assign o_timer_count = count_r;
   assign o_postscaled_match_output = match_r;
   assign o_pwm_period_set = pset_r;
   assign o_pwm_drive = drive_r;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_start;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ST_IDLE && on_r && start_edge && !at_reset_lvl)
      |=> (state_r == ST_RUN && count_r == 8'h00 && drive_r);
   endproperty
   a_start: assert property (p_start)
      else $error("start edge did not start the count");

   property p_resume;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ST_RUN && on_r && is_hlt && start_edge ##1
       (on_r && !start_edge && !sw_clr))
      |=> (count_r == 8'h00 && state_r == ST_RUN) ##1 (count_r == 8'h01);
   endproperty
   a_resume: assert property (p_resume)
      else $error("count did not resume two clocks after reset edge");

   property p_period_clear;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ST_RUN && on_r && !is_mono && period_hit &&
       !start_edge && !at_reset_lvl && !sw_set)
      |=> (count_r == 8'h00 && !on_r && o_postscaled_match_output);
   endproperty
   a_period_clear: assert property (p_period_clear)
      else $error("period match did not clear count and ON");

   property p_ignore_off;
      @(posedge i_clk) disable iff (i_rst)
      !on_r |=> (state_r == ST_IDLE && !pset_r);
   endproperty
   a_ignore_off: assert property (p_ignore_off)
      else $error("edge acted while ON was clear");

   property p_pset_cause;
      @(posedge i_clk) disable iff (i_rst)
      o_pwm_period_set |-> $past(start_edge && on_r);
   endproperty
   a_pset_cause: assert property (p_pset_cause)
      else $error("PWM set pulse without a qualifying edge");

   property p_drive_off;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ST_RUN && on_r && pulse_hit && !at_reset_lvl &&
       !(is_hlt && start_edge)) |=> !drive_r;
   endproperty
   a_drive_off: assert property (p_drive_off)
      else $error("drive stayed active past pulse width match");

   property p_level_hold;
      @(posedge i_clk) disable iff (i_rst)
      (on_r && at_reset_lvl) |=> (count_r == 8'h00 && !o_running);
   endproperty
   a_level_hold: assert property (p_level_hold)
      else $error("count not held at reset level");

   property p_no_reactivate;
      @(posedge i_clk) disable iff (i_rst)
      o_postscaled_match_output |-> !drive_r;
   endproperty
   a_no_reactivate: assert property (p_no_reactivate)
      else $error("drive active at period match");

   property p_mono_stop;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ST_DONE && !start_edge) |=> $stable(count_r);
   endproperty
   a_mono_stop: assert property (p_mono_stop)
      else $error("monostable count moved after halt");

   property p_mono_ignore;
      @(posedge i_clk) disable iff (i_rst)
      (is_mono && state_r == ST_RUN && $stable(i_mode))
      |=> !pset_r;
   endproperty
   a_mono_ignore: assert property (p_mono_ignore)
      else $error("edge during monostable run touched the PWM");

endmodule

`default_nettype wire

/* verif/trig_pwm_partner.sv */
// Far side model: external trigger source and companion PWM.
// Assumes the bench sets i_level off the falling edge.
`timescale 1ns/1ps
`default_nettype none

module trig_pwm_partner
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Bench request and timer restart pulse
   input wire logic i_level,
   input wire logic i_pwm_period_set,
   // Trigger wire and restart tally
   output logic o_trigger,
   output int o_pset_count
);
   initial o_trigger = 1'b0;

   // Bench level moves at the falling edge; take it at the rising edge
   // so the trigger never races the bench in one time step
   always @(posedge i_clk)
      o_trigger <= i_level;

   // PWM side: every start or restart pulse is tallied
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_pset_count <= 0;
      else if (i_pwm_period_set === 1'b1)
         o_pset_count <= o_pset_count + 1;
   end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the one-shot / monostable timer.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "hlt_oneshot_defines.svh"

module testbench;
   localparam logic [7:0] PV = 8'h0a;
   localparam logic [7:0] PW = 8'h03;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [4:0] i_mode = 5'h00;
   logic i_set = 1'b0;
   logic i_clr = 1'b0;
   logic lvl = 1'b0;
   wire logic trg;
   logic o_on, o_running, o_match, o_pset, o_drive;
   logic [7:0] o_cnt;
   int pset_cnt;
   int err_total = 0;
   int samples_checked = 0;

   always #20 i_clk = ~i_clk;

   hlt_oneshot_timer hlt_oneshot_timer_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_mode(i_mode), .i_period_value(PV), .i_pulse_width_value(PW),
      .i_on_set_toggle(i_set), .i_on_clr_toggle(i_clr),
      .i_external_trigger_input(trg), .o_on(o_on),
      .o_running(o_running), .o_timer_count(o_cnt),
      .o_postscaled_match_output(o_match), .o_pwm_period_set(o_pset),
      .o_pwm_drive(o_drive));

   trig_pwm_partner trig_pwm_partner_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_level(lvl), .i_pwm_period_set(o_pset), .o_trigger(trg),
      .o_pset_count(pset_cnt));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk8(input string n, input logic [7:0] e,
      input logic [7:0] s);
      samples_checked++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic s);
      chk8(n, {7'h00, e}, {7'h00, s});
   endtask

   // Outputs are settled at the falling edge, inputs change there too
   task automatic tick(input int n);
      repeat (n)
      begin
         @(negedge i_clk);
         if (o_running === 1'b1)
            chk1("drive", o_cnt <= PW, o_drive);
      end
   endtask

   // sel 0 restart pulse, 1 period match, 2 count zero
   task automatic wait_hi(input int sel);
      int k;
      k = 0;
      while (!((sel == 0 && o_pset === 1'b1) ||
         (sel == 1 && o_match === 1'b1) ||
         (sel == 2 && o_cnt === 8'h00)))
      begin
         k++;
         if (k > 60)
         begin
            $display("CHECK FAILED wait %0d expected 1 seen 0", sel);
            err_total++;
            conclude();
         end
         tick(1);
      end
   endtask

   task automatic trig(input logic v);
      lvl = v;
      tick(1);
   endtask

   task automatic sw_on();
      i_set = ~i_set;
      tick(5);
      chk1("on", 1'b1, o_on);
   endtask

   task automatic sw_off();
      i_clr = ~i_clr;
      tick(5);
      chk1("on", 1'b0, o_on);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk8("count", 8'h00, o_cnt);
      chk1("on", 1'b0, o_on);
      chk1("drive", 1'b0, o_drive);
      $display("test reset done");
   endtask

   // Reset with the monostable halted at the period and the ON set toggle left high, then restart
   task automatic t_midreset();
      i_rst = 1'b1;
      tick(2);
      i_rst = 1'b0;
      tick(5);
      t_reset();
      sw_on();
      trig(1'b0);
      wait_hi(0);
      chk8("count", 8'h00, o_cnt);
      $display("test midreset done");
   endtask

   // Idle is the trigger level before the starting edge
   task automatic t_hlt(input logic [4:0] m, input logic idle);
      int p0;
      int z;
      i_mode = m;
      trig(idle);
      tick(4);
      p0 = pset_cnt;
      trig(~idle);
      tick(6);
      chk1("running", 1'b0, o_running);
      chk8("pset", 8'h00, 8'(pset_cnt - p0));
      trig(idle);
      tick(4);
      sw_on();
      trig(~idle);
      wait_hi(0);
      chk8("count", 8'h00, o_cnt);
      tick(2);
      trig(idle);
      tick(2);
      trig(~idle);
      wait_hi(2);
      z = 0;
      while (o_cnt === 8'h00 && z < 9)
      begin
         z++;
         tick(1);
      end
      chk8("zeros", 8'h02, 8'(z));
      chk8("count", 8'h01, o_cnt);
      wait_hi(1);
      chk8("count", 8'h00, o_cnt);
      chk1("on", 1'b0, o_on);
      chk8("pset", 8'h02, 8'(pset_cnt - p0));
      $display("test hlt %h done", m);
   endtask

   // Rl is the reset level of the mode
   task automatic t_level(input logic [4:0] m, input logic rl);
      logic [7:0] c;
      i_mode = m;
      trig(rl);
      sw_on();
      tick(4);
      chk1("running", 1'b0, o_running);
      trig(~rl);
      wait_hi(0);
      chk1("drive", 1'b1, o_drive);
      tick(4);
      trig(rl);
      tick(4);
      chk8("count", 8'h00, o_cnt);
      chk1("drive", 1'b0, o_drive);
      trig(~rl);
      wait_hi(1);
      chk1("on", 1'b0, o_on);
      chk8("count", 8'h00, o_cnt);
      tick(2);
      chk1("drive", 1'b0, o_drive);
      sw_on();
      tick(8);
      chk1("running", 1'b0, o_running);
      trig(rl);
      tick(3);
      trig(~rl);
      wait_hi(0);
      sw_off();
      chk1("running", 1'b0, o_running);
      chk1("drive", 1'b0, o_drive);
      c = o_cnt;
      tick(3);
      chk8("count", c, o_cnt);
      $display("test level %h done", m);
   endtask

   // S is the trigger level before the starting edge
   task automatic t_mono(input logic [4:0] m, input logic s);
      int p0;
      i_mode = m;
      trig(s);
      tick(4);
      p0 = pset_cnt;
      trig(~s);
      wait_hi(0);
      chk8("count", 8'h00, o_cnt);
      tick(2);
      trig(s);
      tick(2);
      trig(~s);
      wait_hi(1);
      chk8("count", PV, o_cnt);
      chk1("on", 1'b1, o_on);
      chk1("drive", 1'b0, o_drive);
      tick(3);
      chk8("count", PV, o_cnt);
      chk8("pset", 8'h01, 8'(pset_cnt - p0));
      $display("test mono %h done", m);
   endtask

   initial
   begin
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      tick(2);
      t_reset();
      t_hlt(`MODE_HLT_RISE, 1'b0);
      t_hlt(`MODE_HLT_FALL, 1'b1);
      t_level(`MODE_LVL_LOW, 1'b0);
      t_level(`MODE_LVL_HIGH, 1'b1);
      sw_on();
      t_mono(`MODE_MONO_RISE, 1'b0);
      t_mono(`MODE_MONO_FALL, 1'b1);
      t_mono(`MODE_MONO_BOTH, 1'b0);
      t_midreset();
      conclude();
   end
endmodule
`default_nettype wire
